// ==== src/fpwm_timer.sv ====
// Top of the two-channel 14-bit fine PWM timer with its byte register port.
// Assumes a byte CPU port on the system clock; pins feed external low-pass filters.
`timescale 1ns/1ps
module fpwm_timer (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       shared_interface_enable,
  input  wire logic       cpu_sel,
  input  wire logic       cpu_wr,
  input  wire logic       cpu_rd,
  input  wire logic [1:0] cpu_addr,
  input  wire logic [7:0] cpu_wdata,
  output logic [7:0]      cpu_rdata,
  output logic            channel_a_output_pin,
  output logic            channel_b_output_pin
);
  import fpwm_pkg::*;

  // Counter view on the CPU bus: high byte holds counter 7..0, low byte 8..13
  function automatic logic [15:0] fpwm_count_view(input logic [13:0] c, input logic sel);
    logic [15:0] v;
    v = 16'h0000;
    for (int i = 0; i < 8; i++) begin
      v[15 - i] = c[7 - i];
    end
    for (int i = 0; i < 6; i++) begin
      v[7 - i] = c[8 + i];
    end
    v[1] = 1'b1; // [RQ11]
    v[0] = sel;
    return v;
  endfunction : fpwm_count_view

  // Inverse of the counter view
  function automatic logic [13:0] fpwm_count_load(input logic [15:0] v);
    logic [13:0] c;
    c = 14'h0000;
    for (int i = 0; i < 8; i++) begin
      c[7 - i] = v[15 - i];
    end
    for (int i = 0; i < 6; i++) begin
      c[8 + i] = v[7 - i];
    end
    return c;
  endfunction : fpwm_count_load

  // Range window for one data register image
  function automatic logic fpwm_in_range(input logic [15:0] v, input logic carrier_select);
    if (carrier_select) begin
      return (v >= FPWM_RANGE256_MIN) && (v <= FPWM_RANGE256_MAX); // [RQ19]
    end
    return (v >= FPWM_RANGE64_MIN) && (v <= FPWM_RANGE64_MAX); // [RQ18]
  endfunction : fpwm_in_range

  logic [7:0]  ctl;
  logic [13:0] count;
  logic        phase_t;
  logic        reg_sel;
  logic [13:0] data_a;
  logic [13:0] data_b;
  logic        cfs_a;
  logic        cfs_b;
  logic        pin_a;
  logic        pin_b;
  logic [7:0]  rdata;

  logic [7:0]  next_ctl;
  logic [13:0] next_count;
  logic        next_phase_t;
  logic        next_reg_sel;
  logic [13:0] next_data_a;
  logic [13:0] next_data_b;
  logic        next_cfs_a;
  logic        next_cfs_b;
  logic        next_pin_a;
  logic        next_pin_b;
  logic [7:0]  next_rdata;

  logic        access;
  logic        loc0_word;
  logic [15:0] img_a;
  logic [15:0] img_b;
  logic [15:0] img_cnt;
  logic [15:0] loc0_word_in;
  logic [15:0] loc1_word_in;
  logic        loc0_wr_hi;
  logic        loc0_wr_lo;
  logic        loc0_rd_hi;
  logic        loc1_wr_hi;
  logic        loc1_wr_lo;
  logic        loc1_rd_hi;
  logic        loc0_word_wr;
  logic        loc1_word_wr;
  logic [15:0] loc0_word_out;
  logic [15:0] loc1_word_out;
  logic [7:0]  loc0_hold;
  logic [7:0]  loc1_hold;
  logic        tick;
  logic [1:0]  wave;

  // Block answers only when the shared address window belongs to it
  assign access    = cpu_sel & shared_interface_enable; // [RQ6]
  assign loc0_word = ~reg_sel; // [RQ7]

  // Register images as seen by the CPU
  assign img_a   = {data_a, cfs_a, 1'b1}; // [RQ11] [RQ12]
  assign img_b   = {data_b, cfs_b, reg_sel}; // [RQ22]
  assign img_cnt = fpwm_count_view(count, reg_sel);

  assign loc0_word_in = img_a;
  assign loc1_word_in = reg_sel ? img_cnt : img_b; // [RQ7]

  // Byte strobes per location; location 0 is a word only when data is mapped
  assign loc0_wr_hi = access & cpu_wr & loc0_word & (cpu_addr == FPWM_OFS_LOC0_HI);
  assign loc0_wr_lo = access & cpu_wr & loc0_word & (cpu_addr == FPWM_OFS_LOC0_LO);
  assign loc0_rd_hi = access & cpu_rd & loc0_word & (cpu_addr == FPWM_OFS_LOC0_HI);
  assign loc1_wr_hi = access & cpu_wr & (cpu_addr == FPWM_OFS_LOC1_HI);
  assign loc1_wr_lo = access & cpu_wr & (cpu_addr == FPWM_OFS_LOC1_LO);
  assign loc1_rd_hi = access & cpu_rd & (cpu_addr == FPWM_OFS_LOC1_HI);

  // Holding path for channel A data
  fpwm_word_port u_loc0 (
    .clk      (clk),
    .srst     (srst),
    .wr_hi    (loc0_wr_hi),
    .wr_lo    (loc0_wr_lo),
    .rd_hi    (loc0_rd_hi),
    .wbyte    (cpu_wdata),
    .word_in  (loc0_word_in),
    .word_wr  (loc0_word_wr),
    .word_out (loc0_word_out),
    .hold     (loc0_hold)
  );

  // Holding path for channel B data or the counter
  fpwm_word_port u_loc1 (
    .clk      (clk),
    .srst     (srst),
    .wr_hi    (loc1_wr_hi),
    .wr_lo    (loc1_wr_lo),
    .rd_hi    (loc1_rd_hi),
    .wbyte    (cpu_wdata),
    .word_in  (loc1_word_in),
    .word_wr  (loc1_word_wr),
    .word_out (loc1_word_out),
    .hold     (loc1_hold)
  );

  // Resolution tick: every clock, or every second clock
  assign tick = ctl[FPWM_CTL_CKS] ? phase_t : 1'b1; // [RQ4] [RQ5]

  // Control, data and select registers
  always_comb begin
    next_ctl     = ctl;
    next_data_a  = data_a;
    next_data_b  = data_b;
    next_cfs_a   = cfs_a;
    next_cfs_b   = cfs_b;
    next_reg_sel = reg_sel;
    if (access && cpu_wr && reg_sel && (cpu_addr == FPWM_OFS_LOC0_HI)) begin
      next_ctl = (cpu_wdata & ~FPWM_CTL_RSVD_MASK) | FPWM_CTL_RSVD_MASK; // [RQ21]
    end
    if (loc0_word_wr) begin
      next_data_a = loc0_word_out[15:FPWM_DATA_LSB]; // [RQ12]
      next_cfs_a  = loc0_word_out[FPWM_CFS_BIT]; // [RQ11]
    end
    if (loc1_word_wr) begin
      if (!reg_sel) begin
        next_data_b = loc1_word_out[15:FPWM_DATA_LSB]; // [RQ12]
        next_cfs_b  = loc1_word_out[FPWM_CFS_BIT];
      end
      next_reg_sel = loc1_word_out[FPWM_SEL_BIT]; // [RQ22] [RQ24]
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ctl     <= FPWM_CTL_RESET;
      data_a  <= FPWM_DATA_RESET;
      data_b  <= FPWM_DATA_RESET;
      cfs_a   <= FPWM_CFS_RESET;
      cfs_b   <= FPWM_CFS_RESET;
      reg_sel <= FPWM_SEL_RESET;
    end else begin
      ctl     <= next_ctl;
      data_a  <= next_data_a;
      data_b  <= next_data_b;
      cfs_a   <= next_cfs_a;
      cfs_b   <= next_cfs_b;
      reg_sel <= next_reg_sel;
    end
  end

  // Shared time base; a CPU write takes priority over counting
  always_comb begin
    next_phase_t = ~phase_t;
    next_count   = count;
    if (ctl[FPWM_CTL_RUN]) begin
      next_count   = FPWM_COUNT_HALT; // [RQ20]
      next_phase_t = 1'b0;
    end else if (tick) begin
      next_count = count + 14'h0001; // [RQ8] [RQ23]
    end
    if (loc1_word_wr && reg_sel) begin
      next_count = fpwm_count_load(loc1_word_out); // [RQ8]
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      count   <= FPWM_COUNT_RESET;
      phase_t <= 1'b0;
    end else begin
      count   <= next_count;
      phase_t <= next_phase_t;
    end
  end

  // Two identical channels on the one counter
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    fpwm_channel u_chan (
      .clk      (clk),
      .srst     (srst),
      .count    (count), // [RQ9]
      .data     ((ch == 0) ? data_a : data_b),
      .carrier_select      ((ch == 0) ? cfs_a : cfs_b),
      .in_range ((ch == 0) ? fpwm_in_range(img_a, cfs_a) : fpwm_in_range({data_b, cfs_b, 1'b1}, cfs_b)), // [RQ15]
      .wave     (wave[ch])
    ); // [RQ1]
  end

  // Pins gated by enables, optional phase inversion
  always_comb begin
    next_pin_a = ctl[FPWM_CTL_OEA] & (wave[0] ^ ctl[FPWM_CTL_PHASE]); // [RQ21]
    next_pin_b = ctl[FPWM_CTL_OEB] & (wave[1] ^ ctl[FPWM_CTL_PHASE]); // [RQ21]
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pin_a <= 1'b0;
      pin_b <= 1'b0;
    end else begin
      pin_a <= next_pin_a;
      pin_b <= next_pin_b;
    end
  end

  assign channel_a_output_pin = pin_a; // [RQ2]
  assign channel_b_output_pin = pin_b; // [RQ2]

  // Read data: high byte live, low byte from the holding register, or FF at offset 1 while register select is 1
  always_comb begin
    next_rdata = rdata;
    if (access && cpu_rd) begin
      case (cpu_addr)
        FPWM_OFS_LOC0_HI: begin
          next_rdata = reg_sel ? ctl : img_a[15:8]; // [RQ7]
        end
        FPWM_OFS_LOC0_LO: begin
          next_rdata = reg_sel ? FPWM_UNMAPPED_READ : loc0_hold; // [RQ10]
        end
        FPWM_OFS_LOC1_HI: begin
          next_rdata = loc1_word_in[15:8];
        end
        FPWM_OFS_LOC1_LO: begin
          next_rdata = loc1_hold; // [RQ10]
        end
        default: begin
          next_rdata = FPWM_UNMAPPED_READ;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= next_rdata;
    end
  end

  assign cpu_rdata = rdata;

endmodule : fpwm_timer

// ==== src/fpwm_pkg.sv ====
// Constants for the two-channel 14-bit fine PWM timer (fine_pwm_timer).
// Assumes a byte-wide CPU port with two address bits and a 100 MHz system clock.
// Behaviour
// [RQ1] One PWM timer, 14-bit precision, two independent output channels.
// [RQ2] Channel A drives the first output pin, channel B the second.
// [RQ3] Each conversion is spread over many base cycles to cut ripple.
// [RQ4] Resolution T is one or two system clocks, picked by clock select.
// [RQ5] Four operation clocks: two resolutions times two base cycle lengths.
// [RQ6] Registers share addresses; shared interface enable picks who answers.
// [RQ7] Register select 0 maps both data registers; 1 maps control and counter.
// [RQ8] 14-bit readable and writable up-counter, clocked per clock select.
// [RQ9] Counter is both channels' time base; 12-bit use ignores upper two bits.
// [RQ10] 16-bit registers move byte by byte through a holding register.
// [RQ11] Counter low bit 1 and channel A data bit 0 read 1, ignore writes.
// [RQ12] Data value sits in bits 15..2; all data bits reset to 1.
// [RQ13] Counter compared with data every base cycle to set duty.
// [RQ14] Same comparison decides one extra pulse of width T per base cycle.
// [RQ15] Data outside the carrier-dependent range holds the output constant.
// [RQ16] Software keeps the two lowest data bits 0 for 12-bit precision.
// [RQ17] Two lowest data bits are matched against the two top counter bits.
// [RQ18] Carrier select 0: base cycle 64 T, range 0401 to FFFD.
// [RQ19] Carrier select 1 (reset): base cycle 256 T, range 0103 to FFFF.
// [RQ20] Run control 0 counts up; 1 halts the counter at register value 0003.
// [RQ21] Per-channel output enable, reset 0; pin shows the wave only when 1.
// [RQ22] Channel B data bit 0 is a second copy of register select.
// [RQ23] Counter steps once per T and wraps from maximum to zero.
// [RQ24] Either copy of register select writes one shared select state.
package fpwm_pkg;

  // Byte offsets on the CPU port
  localparam logic [1:0] FPWM_OFS_LOC0_HI = 2'h0;
  localparam logic [1:0] FPWM_OFS_LOC0_LO = 2'h1;
  localparam logic [1:0] FPWM_OFS_LOC1_HI = 2'h2;
  localparam logic [1:0] FPWM_OFS_LOC1_LO = 2'h3;

  // Control register fields
  localparam int FPWM_CTL_TEST   = 7;
  localparam int FPWM_CTL_RUN    = 6;
  localparam int FPWM_CTL_OEB    = 3;
  localparam int FPWM_CTL_OEA    = 2;
  localparam int FPWM_CTL_PHASE  = 1;
  localparam int FPWM_CTL_CKS    = 0;
  localparam logic [7:0] FPWM_CTL_RSVD_MASK = 8'h30;
  localparam logic [7:0] FPWM_CTL_RESET     = 8'h30;

  // Data register fields
  localparam int FPWM_DATA_LSB = 2;
  localparam int FPWM_CFS_BIT  = 1;
  localparam int FPWM_SEL_BIT  = 0;

  // Reset values, halt count and unmapped read byte
  localparam logic [13:0] FPWM_DATA_RESET    = 14'h3FFF;
  localparam logic        FPWM_CFS_RESET     = 1'b1;
  localparam logic        FPWM_SEL_RESET     = 1'b1;
  localparam logic [13:0] FPWM_COUNT_RESET   = 14'h0000;
  localparam logic [13:0] FPWM_COUNT_HALT    = 14'h0000;
  localparam logic [7:0]  FPWM_UNMAPPED_READ = 8'hFF;

  // Valid data windows, as full 16-bit register images
  localparam logic [15:0] FPWM_RANGE64_MIN  = 16'h0401;
  localparam logic [15:0] FPWM_RANGE64_MAX  = 16'hFFFD;
  localparam logic [15:0] FPWM_RANGE256_MIN = 16'h0103;
  localparam logic [15:0] FPWM_RANGE256_MAX = 16'hFFFF;

  // Base cycle lengths in T
  localparam int FPWM_BASE_SHORT = 64;
  localparam int FPWM_BASE_LONG  = 256;

endpackage : fpwm_pkg

// ==== src/fpwm_word_port.sv ====
// Holding-register path that moves 16-bit values over a byte port.
// Assumes one strobe at a time; high byte first on write, high byte first on read.
`timescale 1ns/1ps
module fpwm_word_port (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        wr_hi,
  input  wire logic        wr_lo,
  input  wire logic        rd_hi,
  input  wire logic [7:0]  wbyte,
  input  wire logic [15:0] word_in,
  output logic             word_wr,
  output logic [15:0]      word_out,
  output logic [7:0]       hold
);
  import fpwm_pkg::*;

  logic [7:0] next_hold;

  // High write parks in the holder; high read parks the low half
  always_comb begin
    next_hold = hold;
    if (wr_hi) begin
      next_hold = wbyte; // [RQ10]
    end else if (rd_hi) begin
      next_hold = word_in[7:0]; // [RQ10]
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      hold <= 8'h00;
    end else begin
      hold <= next_hold;
    end
  end

  // Low write completes the word in one step
  assign word_wr  = wr_lo; // [RQ10]
  assign word_out = {hold, wbyte};

endmodule : fpwm_word_port

// ==== src/fpwm_channel.sv ====
// One PWM channel: base pulse plus spread fine pulses from the shared counter.
// Assumes the counter and data come from the same clock; output is registered.
`timescale 1ns/1ps
module fpwm_channel (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [13:0] count,
  input  wire logic [13:0] data,
  input  wire logic        carrier_select,
  input  wire logic        in_range,
  output logic             wave
);
  import fpwm_pkg::*;

  // Bit reversal spreads fine pulses evenly over base cycles
  function automatic logic [7:0] fpwm_rev8(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      fpwm_rev8[i] = v[7 - i];
    end
  endfunction : fpwm_rev8

  logic [8:0] pos;
  logic [8:0] duty;
  logic       add;
  logic       next_wave;

  // Split counter and data by carrier length
  always_comb begin
    if (carrier_select) begin
      pos  = {1'b0, count[7:0]}; // [RQ19]
      duty = {1'b0, data[13:6]};
      add  = {2'b00, fpwm_rev8({count[13:8], 2'b00})} < {4'h0, data[5:0]}; // [RQ14] [RQ17]
    end else begin
      pos  = {3'b000, count[5:0]}; // [RQ18]
      duty = {3'b000, data[13:8]};
      add  = fpwm_rev8(count[13:6]) < data[7:0]; // [RQ14] [RQ17]
    end
    next_wave = wave;
    if (in_range) begin
      next_wave = pos < (duty + {8'h00, add}); // [RQ13] [RQ3]
    end // [RQ15]
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wave <= 1'b0;
    end else begin
      wave <= next_wave;
    end
  end

endmodule : fpwm_channel

// ==== tb/fpwm_timer_props.sv ====
// Port-level assertions for the fine PWM timer top.
// Assumes it is bound into fpwm_timer and sees only that module's ports.
`timescale 1ns/1ps
module fpwm_timer_props (
  input wire logic       clk,
  input wire logic       srst,
  input wire logic       shared_interface_enable,
  input wire logic       cpu_sel,
  input wire logic       cpu_wr,
  input wire logic       cpu_rd,
  input wire logic [1:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  input wire logic [7:0] cpu_rdata,
  input wire logic       channel_a_output_pin,
  input wire logic       channel_b_output_pin
);
  import fpwm_pkg::*;
  logic       sel_m;
  logic       next_sel_m;
  logic [7:0] ctl_m;
  logic [7:0] next_ctl_m;
  logic       rd_ok;
  logic       wr_ok;
  // Accepted strobes
  assign rd_ok = cpu_sel && shared_interface_enable && cpu_rd;
  assign wr_ok = cpu_sel && shared_interface_enable && cpu_wr;
  // Mirror of the shared select and the control byte
  always_comb begin
    next_sel_m = sel_m;
    next_ctl_m = ctl_m;
    if (wr_ok && cpu_addr == FPWM_OFS_LOC1_LO) next_sel_m = cpu_wdata[FPWM_SEL_BIT];
    if (wr_ok && sel_m && cpu_addr == FPWM_OFS_LOC0_HI) next_ctl_m = cpu_wdata | FPWM_CTL_RSVD_MASK;
  end
  always_ff @(posedge clk) begin
    sel_m <= srst ? FPWM_SEL_RESET : next_sel_m;
    ctl_m <= srst ? FPWM_CTL_RESET : next_ctl_m;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  rst_quiet_a: assert property ($fell(srst) |->
    cpu_rdata == 8'h00 && !channel_a_output_pin && !channel_b_output_pin) else $error("outputs busy after reset");
  rdata_hold_a: assert property (!rd_ok |=> $stable(cpu_rdata))
    else $error("read byte moved without a read");
  iface_off_a: assert property (cpu_sel && cpu_rd && !shared_interface_enable |=> $stable(cpu_rdata))
    else $error("answered while interface disabled");
  ctl_map_a: assert property (rd_ok && sel_m && cpu_addr == FPWM_OFS_LOC0_HI |=> cpu_rdata == ctl_m)
    else $error("control byte readback wrong");
  lo_unmapped_a: assert property (rd_ok && sel_m && cpu_addr == FPWM_OFS_LOC0_LO |=>
    cpu_rdata == FPWM_UNMAPPED_READ) else $error("offset one not blank under select");
  cnt_rsvd_a: assert property (rd_ok && sel_m && cpu_addr == FPWM_OFS_LOC1_HI ##1 !wr_ok ##1
    rd_ok && cpu_addr == FPWM_OFS_LOC1_LO |=> cpu_rdata[1]) else $error("counter low bit one not set");
  sel_copy_a: assert property (rd_ok && cpu_addr == FPWM_OFS_LOC1_HI ##1 !wr_ok ##1
    rd_ok && cpu_addr == FPWM_OFS_LOC1_LO |=> cpu_rdata[0] == sel_m) else $error("select copy wrong");
  data_rsvd_a: assert property (rd_ok && cpu_addr == FPWM_OFS_LOC0_HI ##1 !wr_ok ##1
    rd_ok && cpu_addr == FPWM_OFS_LOC0_LO |=> cpu_rdata[0]) else $error("location zero bit zero clear");
  oea_off_a: assert property ((!ctl_m[FPWM_CTL_OEA])[*3] |-> !channel_a_output_pin)
    else $error("pin A driven while disabled");
  oeb_off_a: assert property ((!ctl_m[FPWM_CTL_OEB])[*3] |-> !channel_b_output_pin)
    else $error("pin B driven while disabled");
  // Main scenarios reached
  cover property (rd_ok && !sel_m);
  cover property (wr_ok && sel_m && cpu_addr == FPWM_OFS_LOC0_HI);
  cover property ($rose(channel_a_output_pin));
endmodule : fpwm_timer_props
bind fpwm_timer fpwm_timer_props fpwm_timer_props_u (.clk(clk), .srst(srst),
  .shared_interface_enable(shared_interface_enable), .cpu_sel(cpu_sel), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
  .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
  .channel_a_output_pin(channel_a_output_pin), .channel_b_output_pin(channel_b_output_pin));

// ==== tb/fpwm_lpf_model.sv ====
// Integrate-and-dump model of the external low-pass filter on one PWM pin.
// Assumes the bench opens the gate for whole conversion periods, or for a short window while the output is frozen.
`timescale 1ns/1ps
module fpwm_lpf_model (
  input  wire logic   clk,
  input  wire logic   gate,
  input  wire logic   pin,
  output logic [15:0] charge
);
  logic [15:0] next_charge;
  // Charge grows by one per high clock, dumped while the gate is shut
  always_comb begin
    next_charge = gate ? charge + {15'h0000, pin} : 16'h0000;
  end
  always_ff @(posedge clk) begin
    charge <= next_charge;
  end
endmodule : fpwm_lpf_model

// ==== tb/tb.sv ====
// Self-checking bench for the fine PWM timer: byte register tasks and duty checks.
// Assumes a filter model on each pin and a 100 MHz clock.
`timescale 1ns/1ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin fail_count++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (got), (exp)); end end
module tb;
  import fpwm_pkg::*;
  logic        clk, srst, iface_en, cpu_sel, cpu_wr, cpu_rd, gate, pin_a, pin_b;
  logic [1:0]  cpu_addr;
  logic [7:0]  cpu_wdata, cpu_rdata, rb;
  logic [15:0] chg_a, chg_b, w0, w1, span, ea, eb;
  int          fail_count, n_checks;
  // Duty table; case 2 keeps two low bits clear, case 3 puts channel A out of range
  logic [13:0] d_a [4] = '{14'h2000, 14'h1004, 14'h0104, 14'h0010};
  logic [13:0] d_b [4] = '{14'h0155, 14'h3FFF, 14'h0040, 14'h2000};
  logic [1:0]  cf_t [4] = '{2'h2, 2'h1, 2'h1, 2'h1};
  logic [7:0]  ct_t [4] = '{8'h0C, 8'h0D, 8'h0E, 8'h04};

  fpwm_timer dut_u (.clk(clk), .srst(srst), .shared_interface_enable(iface_en), .cpu_sel(cpu_sel),
    .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .channel_a_output_pin(pin_a), .channel_b_output_pin(pin_b));
  fpwm_lpf_model lpf_a_u (.clk(clk), .gate(gate), .pin(pin_a), .charge(chg_a));
  fpwm_lpf_model lpf_b_u (.clk(clk), .gate(gate), .pin(pin_b), .charge(chg_b));

  // One byte access, driven at the falling edge
  task automatic acc(input logic wr, input logic [1:0] a, input logic [7:0] d);
    @(negedge clk);
    cpu_sel   = 1'b1;
    cpu_wr    = wr;
    cpu_rd    = !wr;
    cpu_addr  = a;
    cpu_wdata = d;
    @(negedge clk);
    cpu_sel = 1'b0;
    cpu_wr  = 1'b0;
    cpu_rd  = 1'b0;
    rb      = cpu_rdata;
  endtask : acc
  // Word moves, high byte first through the holder
  task automatic wr16(input logic [1:0] a, input logic [15:0] v);
    acc(1'b1, a, v[15:8]);
    acc(1'b1, a + 2'h1, v[7:0]);
  endtask : wr16
  task automatic rd16(input logic [1:0] a, output logic [15:0] v);
    acc(1'b0, a, 8'h00);
    v[15:8] = rb;
    acc(1'b0, a + 2'h1, 8'h00);
    v[7:0] = rb;
  endtask : rd16
  // Load both channels and control, then integrate n clocks: one whole period, or a short window for a frozen output
  task automatic run_case(input logic [7:0] ctl, input logic [15:0] a, input logic [15:0] b, input int n);
    wr16(FPWM_OFS_LOC1_HI, 16'h0000);
    wr16(FPWM_OFS_LOC0_HI, a);
    wr16(FPWM_OFS_LOC1_HI, b);
    acc(1'b1, FPWM_OFS_LOC0_HI, ctl);
    repeat (8) @(negedge clk);
    gate = 1'b1;
    repeat (n) @(negedge clk);
    gate = 1'b0;
  endtask : run_case
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up

  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Hang guard
  initial begin
    #800_000;
    fail_count++;
    wrap_up();
  end
  // Main sequence
  initial begin
    {srst, iface_en, cpu_sel, cpu_wr, cpu_rd, gate} = 6'h30;
    cpu_addr  = 2'h0;
    cpu_wdata = 8'h00;
    repeat (8) @(negedge clk);
    srst = 1'b0;
    acc(1'b0, FPWM_OFS_LOC0_HI, 8'h00);
    `CHK(rb, 8'h30)
    acc(1'b0, FPWM_OFS_LOC0_LO, 8'h00);
    `CHK(rb, 8'hFF)
    wr16(FPWM_OFS_LOC1_HI, 16'h0000);
    rd16(FPWM_OFS_LOC0_HI, w0);
    `CHK(w0, 16'hFFFF)
    rd16(FPWM_OFS_LOC1_HI, w0);
    `CHK(w0, 16'hFFFE)
    wr16(FPWM_OFS_LOC0_HI, 16'h1232);
    rd16(FPWM_OFS_LOC0_HI, w0);
    `CHK(w0, 16'h1233)
    $display("registers test done");
    for (int i = 0; i < 4; i++) begin
      span = 16'h4000 << ct_t[i][0];
      ea   = {2'h0, d_a[i]} << ct_t[i][0];
      eb   = {2'h0, d_b[i]} << ct_t[i][0];
      // Frozen output needs no whole period; a short window keeps the run brief
      if (i == 3) begin
        span = 16'h0100;
      end
      run_case(ct_t[i], {d_a[i], cf_t[i][1], 1'b0}, {d_b[i], cf_t[i][0], 1'b1}, span);
      if (i < 3) begin
        `CHK(chg_a, ct_t[i][1] ? span - ea : ea)
        `CHK(chg_b, ct_t[i][1] ? span - eb : eb)
      end else begin
        `CHK(chg_a == 16'h0000 || chg_a == span, 1'b1)
        `CHK(chg_b, 16'h0000)
      end
    end
    $display("duty test done");
    for (int k = 0; k < 2; k++) begin
      acc(1'b1, FPWM_OFS_LOC0_HI, {7'h00, k[0]});
      rd16(FPWM_OFS_LOC1_HI, w0);
      repeat (96) @(negedge clk);
      rd16(FPWM_OFS_LOC1_HI, w1);
      `CHK(w1[15:8] - w0[15:8], 8'h64 >> k)
      `CHK(w1[1:0], 2'h3)
    end
    $display("counter test done");
    acc(1'b1, FPWM_OFS_LOC0_HI, 8'h40);
    acc(1'b0, FPWM_OFS_LOC0_HI, 8'h00);
    `CHK(rb, 8'h70)
    rd16(FPWM_OFS_LOC1_HI, w0);
    `CHK(w0, 16'h0003)
    iface_en = 1'b0;
    acc(1'b1, FPWM_OFS_LOC0_HI, 8'h0C);
    acc(1'b0, FPWM_OFS_LOC0_HI, 8'h00);
    iface_en = 1'b1;
    acc(1'b0, FPWM_OFS_LOC0_HI, 8'h00);
    `CHK(rb, 8'h70)
    $display("halt and sharing test done");
    wrap_up();
  end
endmodule : tb
